// ==== shp_hold_port.sv ====
// Serial slave port with pause (hold) control
// What this block does
// - Pause freezes sequence, keeps bit count
// - Pause acts at once if clock low
// - While paused, clock and data ignored
// - Resume only if pause rises, clock low
// - Pause low always tri-states data output
// - Select high deselects and tri-states output
// - Sample on rising, update after falling
`timescale 1ns/1ps
`default_nettype none
module shp_hold_port
   import shp_pkg::*;
#(
   parameter int UNIT_BITS = shp_pkg::SHP_UNIT_BITS
) (
   // Clock and reset
   input  wire logic                   clk_in,
   input  wire logic                   nrst_in,
   // Serial pins from the master
   input  wire logic                   sel_n_in,
   input  wire logic                   sck_in,
   input  wire logic                   si_in,
   input  wire logic                   pause_n_in,
   // Serial data output pin
   output logic                        so_out,
   output logic                        so_oe_out,
   // Core side: data to send and data received
   input  wire logic [UNIT_BITS-1:0]   tx_unit_in,
   output logic      [UNIT_BITS-1:0]   rx_unit_out,
   output logic                        rx_valid_out,
   output logic                        paused_out,
   output logic                        active_out
);
   import shp_pkg::*;

   localparam int CW = $clog2(UNIT_BITS);

   shp_pins_t              pins;
   shp_pins_t              pins_prev_reg;
   shp_state_t             state_reg, state_next;
   logic [CW-1:0]          bit_reg, bit_next;
   logic [UNIT_BITS-1:0]   shin_reg, shin_next;
   logic [UNIT_BITS-1:0]   shout_reg, shout_next;
   logic [UNIT_BITS-1:0]   rx_reg, rx_next;
   logic                   rxv_reg, rxv_next;
   shp_so_t                so_reg, so_next;
   logic                   sck_rise, sck_fall, pause_fall, pause_rise, sel_fall;
   logic                   run;
   logic                   paused_reg;
   logic                   active_reg;

   // Pins pass two flip-flops before any logic reads them
   shp_sync #(
      .WIDTH (4)
   ) u_sync (
      .clk_in     (clk_in),
      .nrst_in    (nrst_in),
      .async_in   ({sel_n_in, sck_in, si_in, pause_n_in}),
      .rst_val_in ({SHP_PIN_IDLE, 1'h0, 1'h0, SHP_PIN_IDLE}),
      .sync_out   (pins)
   );

   // Edge detection works on synchronised levels only
   always_comb begin
      sck_rise   = pins.sck & ~pins_prev_reg.sck;
      sck_fall   = ~pins.sck & pins_prev_reg.sck;
      pause_fall = ~pins.pause_n & pins_prev_reg.pause_n;
      pause_rise = pins.pause_n & ~pins_prev_reg.pause_n;
      sel_fall   = ~pins.sel_n & pins_prev_reg.sel_n;
   end

   // Port state machine
   always_comb begin
      state_next = state_reg;
      if (pins.sel_n) begin
         state_next = SHP_IDLE;
      end else begin
         unique case (state_reg)
            SHP_IDLE: begin
               // A fresh select fall is needed to start a sequence
               if (sel_fall) begin
                  state_next = SHP_ACTIVE;
               end
            end
            SHP_ACTIVE: begin
               if (!pins.pause_n) begin
                  // Clock low: pause now; clock high: wait for its fall
                  state_next = pins.sck ? SHP_PAUSE_PEND : SHP_PAUSED;
               end
            end
            SHP_PAUSE_PEND: begin
               if (pins.pause_n) begin
                  state_next = SHP_ACTIVE;
               end else if (sck_fall) begin
                  state_next = SHP_PAUSED;
               end
            end
            SHP_PAUSED: begin
               // Rise while clock high is not a resume
               if (pause_rise && !pins.sck) begin
                  state_next = SHP_ACTIVE;
               end
            end
         endcase
      end
   end

   // Shifting runs only while active with pause up, or while pending whatever the pause level
   assign run = (state_reg == SHP_ACTIVE && pins.pause_n) || (state_reg == SHP_PAUSE_PEND);

   // Shift path; counters hold their value through a pause
   always_comb begin
      bit_next   = bit_reg;
      shin_next  = shin_reg;
      shout_next = shout_reg;
      rx_next    = rx_reg;
      rxv_next   = 1'h0;
      so_next    = so_reg;
      if (state_reg == SHP_IDLE) begin
         bit_next   = '0;
         shout_next = tx_unit_in;
      end
      if (run && sck_rise) begin
         shin_next = {shin_reg[UNIT_BITS-2:0], pins.si};
         if (bit_reg == CW'(UNIT_BITS-1)) begin
            bit_next = '0;
            rx_next  = {shin_reg[UNIT_BITS-2:0], pins.si};
            rxv_next = 1'h1;
         end else begin
            bit_next = bit_reg + 1'h1;
         end
      end
      if (run && sck_fall) begin
         so_next.d  = shout_reg[UNIT_BITS-1];
         shout_next = (bit_reg == '0) ? tx_unit_in : {shout_reg[UNIT_BITS-2:0], 1'h0};
      end
      // Output enabled only while selected, active and not paused
      so_next.oe = ~pins.sel_n & pins.pause_n & (state_reg != SHP_IDLE) & (state_reg != SHP_PAUSED);
      if (pins.sel_n) begin
         so_next.oe = 1'h0;
      end
   end

   // Registers
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         state_reg     <= SHP_IDLE;
         bit_reg       <= '0;
         shin_reg      <= '0;
         shout_reg     <= '0;
         rx_reg        <= '0;
         rxv_reg       <= 1'h0;
         so_reg        <= '{d: SHP_SO_RESET, oe: 1'h0};
         pins_prev_reg <= '{sel_n: 1'h1, sck: 1'h0, si: 1'h0, pause_n: 1'h1};
         paused_reg    <= 1'h0;
         active_reg    <= 1'h0;
      end else begin
         state_reg     <= state_next;
         bit_reg       <= bit_next;
         shin_reg      <= shin_next;
         shout_reg     <= shout_next;
         rx_reg        <= rx_next;
         rxv_reg       <= rxv_next;
         so_reg        <= so_next;
         pins_prev_reg <= pins;
         // Status flops track the state register, so no decode glitch reaches a pin
         paused_reg    <= (state_next == SHP_PAUSED);
         active_reg    <= (state_next == SHP_ACTIVE);
      end
   end

   // Outputs straight from flip-flops
   assign so_out       = so_reg.d;
   assign so_oe_out    = so_reg.oe;
   assign rx_unit_out  = rx_reg;
   assign rx_valid_out = rxv_reg;
   assign paused_out   = paused_reg;
   assign active_out   = active_reg;

   // Checks
   oe_pause_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      !pins.pause_n |=> !so_reg.oe) else $error("output driven during pause");
   oe_desel_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      pins.sel_n |=> !so_reg.oe && state_reg == SHP_IDLE) else $error("output driven while deselected");
   pause_now_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_ACTIVE && !pins.sel_n && !pins.pause_n && !pins.sck |=> state_reg == SHP_PAUSED)
      else $error("pause with clock low not immediate");
   pause_defer_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_ACTIVE && !pins.sel_n && !pins.pause_n && pins.sck |=> state_reg == SHP_PAUSE_PEND)
      else $error("pause with clock high not deferred");
   frozen_bits_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_PAUSED && !pins.sel_n |=> bit_reg == $past(bit_reg) && shin_reg == $past(shin_reg))
      else $error("bit count moved during pause");
   no_resume_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_PAUSED && pause_rise && pins.sck |=> state_reg != SHP_ACTIVE)
      else $error("resumed with clock high");
   resume_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_PAUSED && !pins.sel_n && pause_rise && !pins.sck |=> state_reg == SHP_ACTIVE)
      else $error("resume with clock low refused");
   rise_sample_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      run && sck_rise && !pins.sel_n |=> shin_reg[0] == $past(pins.si)) else $error("input not sampled");
   keep_pos_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
      state_reg == SHP_PAUSED ##1 state_reg == SHP_ACTIVE |-> bit_reg == $past(bit_reg, 1))
      else $error("bit position lost over resume");
endmodule
`default_nettype wire

// ==== shp_pkg.sv ====
// Package for the serial port pause control block
package shp_pkg;
   // Bench link clock period and system clock period, in ns
   localparam int SHP_SCK_PERIOD_NS = 125;
   localparam int SHP_CLK_PERIOD_NS = 10;
   // Synchroniser depth
   localparam int SHP_SYNC_STAGES   = 2;
   // Default shift width of one serial unit
   localparam int SHP_UNIT_BITS     = 8;
   // Reset values
   localparam logic SHP_PIN_IDLE    = 1'h1;
   localparam logic SHP_SO_RESET    = 1'h0;
   // Port state
   typedef enum logic [1:0] {
      SHP_IDLE,
      SHP_ACTIVE,
      SHP_PAUSE_PEND,
      SHP_PAUSED
   } shp_state_t;
   // Sampled serial pins, after synchronisation
   typedef struct packed {
      logic sel_n;
      logic sck;
      logic si;
      logic pause_n;
   } shp_pins_t;
   // Serial data output pin as value and enable
   typedef struct packed {
      logic d;
      logic oe;
   } shp_so_t;
endpackage

// ==== shp_sync.sv ====
// Two flip-flop synchroniser for a group of serial pins
`timescale 1ns/1ps
`default_nettype none
module shp_sync #(
   parameter int WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             nrst_in,
   // Pins and synchronised levels
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] rst_val_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   // First stage feeds only the second stage
   always_comb begin
      meta_next = async_in;
      sync_next = meta_reg;
   end

   // Reset value is a static tie at the instance
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         meta_reg <= rst_val_in;
         sync_reg <= rst_val_in;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign sync_out = sync_reg;
endmodule
`default_nettype wire

// ==== shp_master_model.sv ====
// Serial master model driving select, clock, data and pause pins
`timescale 1ns/1ps
`default_nettype none
module shp_master_model (
   // Pins toward the port
   output logic sel_n_out,
   output logic sck_out,
   output logic si_out,
   output logic pause_n_out
);
   // Idle: deselected, clock parked low, pause released
   initial begin
      sel_n_out   = 1'h1;
      sck_out     = 1'h0;
      si_out      = 1'h0;
      pause_n_out = 1'h1;
   end
   // Select stays low across a pause; only the bench ends a frame
   task automatic sel(input logic l);
      sel_n_out = l;
   endtask
   // Pause edges land where the bench puts the clock level
   task automatic pause(input logic l);
      pause_n_out = l;
   endtask
   // Data first, clock rises half of a 125 ns period later
   task automatic rise(input logic b);
      si_out = b;
      #62.5;
      sck_out = 1'h1;
      #62.5;
   endtask
   // Clock falls only; data moves at the next rise call, never twice at once
   task automatic fall();
      sck_out = 1'h0;
   endtask
endmodule
`default_nettype wire

// ==== shp_hold_port_tb_top.sv ====
// Self-checking bench for the pause control port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module shp_hold_port_tb_top;
   import shp_pkg::*;
   // Clock, reset, pins and model state
   logic       clk_in = 1'h0;
   logic       nrst_in = 1'h0;
   logic       sel_n, sck, si, pause_n, so, so_oe, rx_valid, paused, active;
   logic [7:0] tx_unit = 8'h00;
   logic [7:0] rx_unit;
   int         fails = 0, n_checks = 0, seed = 22, cycles = 0, acc = 0, cnt = 0;
   int         exp_q[$];
   always #5 clk_in = ~clk_in;
   shp_master_model i_m (.sel_n_out(sel_n), .sck_out(sck), .si_out(si), .pause_n_out(pause_n));
   shp_hold_port #(.UNIT_BITS(8)) i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .sel_n_in(sel_n), .sck_in(sck),
      .si_in(si), .pause_n_in(pause_n), .so_out(so), .so_oe_out(so_oe), .tx_unit_in(tx_unit),
      .rx_unit_out(rx_unit), .rx_valid_out(rx_valid), .paused_out(paused), .active_out(active));
   // Compare every received unit with the model; cut a hang short
   always @(posedge clk_in) begin
      cycles++;
      if (rx_valid === 1'h1) begin
         `CHK("rx_pending", 1'h1, exp_q.size() > 0)
         `CHK("rx_unit", 8'(exp_q.pop_front()), rx_unit)
      end
      if (cycles == 5000) begin
         fails++;
         report_and_stop();
      end
   end
   // Reference model: MSB first, eight bits a unit
   task automatic model(input logic b);
      acc = (acc << 1) | int'(b);
      cnt++;
      if (cnt == 8) begin
         exp_q.push_back(acc & 255);
         cnt = 0;
         acc = 0;
      end
   endtask
   // Send bits hi down to lo of v
   task automatic send(input logic [7:0] v, input int hi, input int lo);
      for (int i = hi; i >= lo; i--) begin
         // Model first: the received unit can appear before the clock falls
         model(v[i]);
         i_m.rise(v[i]);
         if (i != 7) begin
            `CHK("so_bit", tx_unit[i+1], so)
            `CHK("so_oe", 1'h1, so_oe)
         end
         i_m.fall();
      end
   endtask
   // Covers the sync plus edge detect latency with margin
   task automatic settle();
      repeat (8) @(posedge clk_in);
      #1;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      logic [7:0] v;
      repeat (3) @(posedge clk_in);
      #1;
      nrst_in = 1'h1;
      tx_unit = 8'($random(seed));
      settle();
      `CHK("oe_idle", 1'h0, so_oe)
      `CHK("act_idle", 1'h0, active)
      // Whole unit, then a pause entered with the clock low
      i_m.sel(1'h0);
      settle();
      `CHK("active", 1'h1, active)
      send(8'($random(seed)), 7, 0);
      v = 8'($random(seed));
      send(v, 7, 5);
      settle();
      i_m.pause(1'h0);
      settle();
      `CHK("paused", 1'h1, paused)
      `CHK("oe_paused", 1'h0, so_oe)
      i_m.rise(~v[4]);
      i_m.fall();
      settle();
      `CHK("still_paused", 1'h1, paused)
      i_m.pause(1'h1);
      settle();
      `CHK("resumed", 1'h1, active)
      send(v, 4, 0);
      settle();
      `CHK("drained1", 0, exp_q.size())
      $display("test pause_clock_low done");
      // Pause with clock high defers; resume with clock high refused
      v = 8'($random(seed));
      send(v, 7, 4);
      model(v[3]);
      i_m.rise(v[3]);
      i_m.pause(1'h0);
      settle();
      `CHK("deferred", 1'h0, paused)
      `CHK("oe_deferred", 1'h0, so_oe)
      i_m.fall();
      settle();
      `CHK("defer_taken", 1'h1, paused)
      i_m.rise(1'h0);
      i_m.pause(1'h1);
      settle();
      `CHK("no_resume", 1'h1, paused)
      i_m.fall();
      i_m.pause(1'h0);
      settle();
      i_m.pause(1'h1);
      settle();
      `CHK("resume2", 1'h0, paused)
      send(v, 2, 0);
      settle();
      `CHK("drained2", 0, exp_q.size())
      $display("test pause_clock_high done");
      // Deselect mid-unit drops the partial unit and floats the output
      send(v, 7, 5);
      cnt = 0;
      acc = 0;
      i_m.sel(1'h1);
      settle();
      `CHK("oe_desel", 1'h0, so_oe)
      `CHK("act_desel", 1'h0, active)
      $display("test deselect done");
      report_and_stop();
   end
endmodule
`default_nettype wire
